//--- core/touch_cfg_pkg.sv
// Purpose: constants for the ten-button touch configuration register bank
// Assumes: byte-wide register port behind the two-wire slave front end
// Notes: offsets are register indices on the slave's byte address space
// Function
// R1 - one group bit per button selects suppression
// R2 - suppress only buttons whose group bit set
// R3 - toggle bit makes linked output flip per touch
// R4 - sensitivity 00/01 high, 10 medium, 11 low
// R5 - button 0 debounce, reset 1, range 1-255
// R6 - buttons 1-9 share debounce, reset 1, 1-255
// R7 - touch reported after debounce-count consecutive scans
// R8 - host enters configuration mode 010 before writing
// R9 - save bit stores configuration into non-volatile storage
package touch_cfg_pkg;

  // ************************************************************
  // register indices
  // ************************************************************
  localparam logic [7:0] SUPP_LOW_ADDR = 8'h03;
  localparam logic [7:0] SUPP_HIGH_ADDR = 8'h04;
  localparam logic [7:0] TOGGLE_LOW_ADDR = 8'h06;
  localparam logic [7:0] TOGGLE_HIGH_ADDR = 8'h07;
  localparam logic [7:0] SENS_0_3_ADDR = 8'h09;
  localparam logic [7:0] SENS_4_7_ADDR = 8'h0A;
  localparam logic [7:0] SENS_8_9_ADDR = 8'h0B;
  localparam logic [7:0] DEB_ZERO_ADDR = 8'h0E;
  localparam logic [7:0] DEB_REST_ADDR = 8'h0F;

  // ************************************************************
  // reset values and field layout
  // ************************************************************
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] DEB_RESET = 8'h01;
  localparam logic [1:0] HIGH_PART_MASK = 2'h3;
  localparam int BUTTONS = 10;
  localparam int LOW_BUTTONS = 8;
  localparam int SENS_W = 2;
  localparam int IMAGE_W = 72;

  // ************************************************************
  // modes and sensitivity levels
  // ************************************************************
  typedef enum logic [2:0]
  {
    MODE_OPERATE = 3'b000,
    MODE_LED_CFG = 3'b001,
    MODE_DEV_CFG = 3'b010,
    MODE_TEST = 3'b011,
    MODE_DEBUG = 3'b100
  } device_mode_type;

  typedef enum logic [1:0]
  {
    SENS_HIGH = 2'b00,
    SENS_MEDIUM = 2'b01,
    SENS_LOW = 2'b10
  } sens_level_type;

endpackage : touch_cfg_pkg

//--- core/touch_button_config_regs.sv
// Purpose: configuration registers and per-button touch post-processing
// Assumes: one clock mclk, raw detections sampled on scan_tick
// Notes: writes land only in device configuration mode
`timescale 1ns/100ps
`default_nettype none
module touch_button_config_regs
  import touch_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [2:0] device_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic save_req,
  output logic nvm_write_valid,
  output logic [IMAGE_W-1:0] nvm_write_image,
  input wire logic scan_tick,
  input wire logic [BUTTONS-1:0] raw_detect,
  output logic [BUTTONS-1:0] button_touched,
  output logic [BUTTONS-1:0] button_linked_output_n,
  output logic [2*BUTTONS-1:0] button_sensitivity_code
);

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [BUTTONS-1:0] supp_member_q;
  logic [BUTTONS-1:0] toggle_en_q;
  logic [2*BUTTONS-1:0] sens_q;
  logic [7:0] deb_zero_q;
  logic [7:0] deb_rest_q;
  logic cfg_wr;

  // the mode lives outside; writes outside configuration mode are dropped
  assign cfg_wr = reg_wr && (device_mode == MODE_DEV_CFG); // R8

  // host writes; a zero debounce is refused so counts stay in 1..255
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      supp_member_q <= '0;
      toggle_en_q <= '0;
      sens_q <= '0;
      deb_zero_q <= DEB_RESET; // R5
      deb_rest_q <= DEB_RESET; // R6
    end
    else if (cfg_wr)
    begin
      unique case (reg_addr)
        SUPP_LOW_ADDR: supp_member_q[LOW_BUTTONS-1:0] <= reg_wdata; // R1
        SUPP_HIGH_ADDR: supp_member_q[BUTTONS-1:LOW_BUTTONS] <= reg_wdata[1:0]; // R1
        TOGGLE_LOW_ADDR: toggle_en_q[LOW_BUTTONS-1:0] <= reg_wdata; // R3
        TOGGLE_HIGH_ADDR: toggle_en_q[BUTTONS-1:LOW_BUTTONS] <= reg_wdata[1:0]; // R3
        SENS_0_3_ADDR: sens_q[7:0] <= reg_wdata; // R4
        SENS_4_7_ADDR: sens_q[15:8] <= reg_wdata; // R4
        SENS_8_9_ADDR: sens_q[19:16] <= reg_wdata[3:0]; // R4
        DEB_ZERO_ADDR:
        begin
          if (reg_wdata != BYTE_ZERO)
            deb_zero_q <= reg_wdata; // R5
        end
        DEB_REST_ADDR:
        begin
          if (reg_wdata != BYTE_ZERO)
            deb_rest_q <= reg_wdata; // R6
        end
        default: ;
      endcase
    end
  end

  // read mux; unused offsets and reserved bits read zero
  always_comb
  begin
    unique case (reg_addr)
      SUPP_LOW_ADDR: reg_rdata = supp_member_q[LOW_BUTTONS-1:0];
      SUPP_HIGH_ADDR: reg_rdata = {6'h00, supp_member_q[BUTTONS-1:LOW_BUTTONS]};
      TOGGLE_LOW_ADDR: reg_rdata = toggle_en_q[LOW_BUTTONS-1:0];
      TOGGLE_HIGH_ADDR: reg_rdata = {6'h00, toggle_en_q[BUTTONS-1:LOW_BUTTONS]};
      SENS_0_3_ADDR: reg_rdata = sens_q[7:0];
      SENS_4_7_ADDR: reg_rdata = sens_q[15:8];
      SENS_8_9_ADDR: reg_rdata = {4'h0, sens_q[19:16]};
      DEB_ZERO_ADDR: reg_rdata = deb_zero_q;
      DEB_REST_ADDR: reg_rdata = deb_rest_q;
      default: reg_rdata = BYTE_ZERO;
    endcase
  end

  // ************************************************************
  // save to non-volatile storage
  // ************************************************************
  // snapshot taken in one cycle so a later write cannot tear the image
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nvm_write_valid <= 1'b0;
      nvm_write_image <= '0;
    end
    else
    begin
      nvm_write_valid <= save_req; // R9
      if (save_req)
        nvm_write_image <= {deb_rest_q, deb_zero_q, 4'h0, sens_q, 6'h00, toggle_en_q,
                            6'h00, supp_member_q}; // R9
    end
  end

  // ************************************************************
  // sensitivity decode
  // ************************************************************
  // codes 00 and 01 both mean high, folded here so the sensor sees three levels
  always_comb
  begin
    for (int i = 0; i < BUTTONS; i++)
    begin
      unique case (sens_q[SENS_W*i +: SENS_W])
        2'b00, 2'b01: button_sensitivity_code[SENS_W*i +: SENS_W] = SENS_HIGH; // R4
        2'b10: button_sensitivity_code[SENS_W*i +: SENS_W] = SENS_MEDIUM; // R4
        default: button_sensitivity_code[SENS_W*i +: SENS_W] = SENS_LOW; // R4
      endcase
    end
  end

  // ************************************************************
  // flanking suppression
  // ************************************************************
  logic [BUTTONS-1:0] filtered;
  logic group_seen;

  // among group members only the lowest detecting one survives; others pass
  always_comb
  begin
    group_seen = 1'b0;
    for (int i = 0; i < BUTTONS; i++)
    begin
      filtered[i] = raw_detect[i]; // R2
      if (supp_member_q[i] && raw_detect[i])
      begin
        filtered[i] = !group_seen; // R1
        group_seen = 1'b1;
      end
    end
  end

  // ************************************************************
  // debounce and toggle
  // ************************************************************
  logic [7:0] deb_cnt_q [BUTTONS];
  logic [BUTTONS-1:0] toggle_state_q;

  // counter saturates at the limit; one miss clears touch and count
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < BUTTONS; i++)
        deb_cnt_q[i] <= BYTE_ZERO;
      button_touched <= '0;
    end
    else if (scan_tick)
    begin
      for (int i = 0; i < BUTTONS; i++)
      begin
        if (!filtered[i])
        begin
          deb_cnt_q[i] <= BYTE_ZERO; // R7
          button_touched[i] <= 1'b0; // R7
        end
        else if (deb_cnt_q[i] != ((i == 0) ? deb_zero_q : deb_rest_q))
        begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 8'h01;
          button_touched[i] <= (deb_cnt_q[i] + 8'h01) == ((i == 0) ? deb_zero_q : deb_rest_q); // R7
        end
      end
    end
  end

  logic [BUTTONS-1:0] touched_prev_q;

  // toggle state flips on each new touch, only while toggle is enabled
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      touched_prev_q <= '0;
      toggle_state_q <= '0;
    end
    else
    begin
      touched_prev_q <= button_touched;
      for (int i = 0; i < BUTTONS; i++)
        if (toggle_en_q[i] && button_touched[i] && !touched_prev_q[i])
          toggle_state_q[i] <= !toggle_state_q[i]; // R3
    end
  end

  // outputs are active low, driving an led to ground when on
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      button_linked_output_n <= '1;
    else
      for (int i = 0; i < BUTTONS; i++)
        button_linked_output_n[i] <= toggle_en_q[i] ? !toggle_state_q[i] : !button_touched[i]; // R3
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence deb0_write_s;
    cfg_wr && reg_addr == DEB_ZERO_ADDR;
  endsequence

  deb_zero_write_a: assert property (deb0_write_s ##0 (reg_wdata != BYTE_ZERO) |=> // R5
    deb_zero_q == $past(reg_wdata)) else $error("button 0 debounce write lost");
  deb_zero_keep_a: assert property (deb0_write_s ##0 (reg_wdata == BYTE_ZERO) |=> // R5
    $stable(deb_zero_q) && deb_zero_q != BYTE_ZERO) else $error("zero debounce accepted");
  deb_rest_write_a: assert property (cfg_wr && reg_addr == DEB_REST_ADDR && reg_wdata != BYTE_ZERO |=> // R6
    deb_rest_q == $past(reg_wdata)) else $error("shared debounce write lost");
  mode_gate_a: assert property (reg_wr && device_mode != MODE_DEV_CFG |=> // R8
    $stable(supp_member_q) && $stable(deb_rest_q)) else $error("write outside config mode");
  group_write_a: assert property (cfg_wr && reg_addr == SUPP_HIGH_ADDR |=> // R1
    supp_member_q[9:8] == $past(reg_wdata[1:0])) else $error("group high bits wrong");
  non_member_pass_a: assert property (!supp_member_q[1] |-> filtered[1] == raw_detect[1]) // R2
    else $error("non member suppressed");
  sens_decode_a: assert property (sens_q[1] == 1'b0 |-> button_sensitivity_code[1:0] == SENS_HIGH) // R4
    else $error("sensitivity decode wrong");
  miss_clears_a: assert property (scan_tick && !filtered[0] |=> !button_touched[0] ##1 // R7
    button_linked_output_n[0] || $past(toggle_en_q[0])) else $error("touch kept after miss");
  touch_needs_count_a: assert property ($rose(button_touched[0]) |-> deb_cnt_q[0] == deb_zero_q) // R7
    else $error("touch before debounce count");
  toggle_flip_a: assert property (toggle_en_q[0] && $rose(button_touched[0]) && toggle_en_q[0] |=> // R3
    toggle_state_q[0] != $past(toggle_state_q[0])) else $error("toggle did not flip");
  save_pulse_a: assert property (save_req |=> nvm_write_valid && // R9
    nvm_write_image[71:64] == $past(deb_rest_q)) else $error("save image wrong");

endmodule : touch_button_config_regs
`default_nettype wire

//--- verif/host_model.sv
// Purpose: host side of the configuration register port
// Assumes: drives only just after mclk rising edges
// Notes: one strobe pulse a byte; released data is inverted
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  input wire logic mclk,
  output logic [2:0] device_mode,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic save_req
);
  // idle port at time zero
  initial
  begin
    device_mode = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    save_req = 1'b0;
  end
  // mode is set before a write burst, as the device refuses writes otherwise
  task automatic mode(input logic [2:0] m);
    @(posedge mclk);
    device_mode <= m;
  endtask : mode
  // one byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data must not look valid
  endtask : wr
  // read select only, the read data is combinational
  task automatic sel(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
  endtask : sel
  // save bit written to 1
  task automatic save();
    @(posedge mclk);
    save_req <= 1'b1;
    @(posedge mclk);
    save_req <= 1'b0;
  endtask : save
endmodule : host_model
`default_nettype wire

//--- verif/touch_button_config_regs_tb_top.sv
// Purpose: self-checking bench for the touch configuration bank
// Assumes: host_model drives the register port
// Notes: read and image results are compared from queues at negedge
`timescale 1ns/100ps
`default_nettype none
module touch_button_config_regs_tb_top
  import touch_cfg_pkg::*;
;
  logic mclk, reset_n, reg_wr, save_req, scan_tick, nvm_write_valid;
  logic [2:0] device_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [IMAGE_W-1:0] nvm_write_image;
  logic [BUTTONS-1:0] raw_detect, button_touched, button_linked_output_n;
  logic [2*BUTTONS-1:0] button_sensitivity_code;
  logic [7:0] rd_q [$];
  logic [IMAGE_W-1:0] img_q [$];
  logic [7:0] sh [9];
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  localparam logic [7:0] ADR [9] = '{SUPP_LOW_ADDR, SUPP_HIGH_ADDR, TOGGLE_LOW_ADDR, TOGGLE_HIGH_ADDR,
    SENS_0_3_ADDR, SENS_4_7_ADDR, SENS_8_9_ADDR, DEB_ZERO_ADDR, DEB_REST_ADDR};
  localparam logic [7:0] MSK [9] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF};

  host_model u_host (.mclk(mclk), .device_mode(device_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .save_req(save_req));
  touch_button_config_regs u_dut (.mclk(mclk), .reset_n(reset_n), .device_mode(device_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .save_req(save_req), .nvm_write_valid(nvm_write_valid), .nvm_write_image(nvm_write_image),
    .scan_tick(scan_tick), .raw_detect(raw_detect), .button_touched(button_touched),
    .button_linked_output_n(button_linked_output_n), .button_sensitivity_code(button_sensitivity_code));

  // 250 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [71:0] s, input logic [71:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // compare the oldest note with what the port shows, once settled
  always @(negedge mclk)
  begin
    if (rd_q.size() > 0)
      chk("rdata", reg_rdata, rd_q.pop_front());
    if (nvm_write_valid)
      chk("image", nvm_write_image, (img_q.size() > 0) ? img_q.pop_front() : 'x);
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host.sel(a);
    rd_q.push_back(e);
  endtask : rd

  // read back every register, then save and check the stored image
  task automatic rd_all();
    for (int i = 0; i < 9; i++)
      rd(ADR[i], sh[i]);
    img_q.push_back({sh[8], sh[7], 4'h0, sh[6][3:0], sh[5], sh[4], 6'h0, sh[3][1:0], sh[2], 6'h0,
      sh[1][1:0], sh[0]});
    u_host.save();
    repeat (2) @(posedge mclk);
  endtask : rd_all

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++)
      sh[i] = (i > 6) ? DEB_RESET : BYTE_ZERO;
  endtask : do_reset

  // one scan result; the line is scrambled once the tick is gone
  task automatic tick(input logic [9:0] d);
    @(posedge mclk);
    scan_tick <= 1'b1;
    raw_detect <= d;
    @(posedge mclk);
    scan_tick <= 1'b0;
    raw_detect <= ~d;
    @(negedge mclk);
  endtask : tick

  initial
  begin
    reset_n = 1'b0;
    scan_tick = 1'b0;
    raw_detect = '0;
    void'($urandom(32'h3877));
    do_reset();
    rd(8'h05, BYTE_ZERO);
    rd_all();
    $display("test reset values done");
    u_host.mode(MODE_DEV_CFG);
    for (int i = 0; i < 9; i++)
    begin
      v = 8'($urandom());
      if (i > 6 && v == 8'h00)
        v = 8'h01;
      u_host.wr(ADR[i], v);
      sh[i] = v & MSK[i];
    end
    rd_all();
    $display("test random writes done");
    u_host.wr(DEB_ZERO_ADDR, 8'h00);
    u_host.wr(DEB_REST_ADDR, 8'h00);
    u_host.mode(MODE_OPERATE);
    for (int i = 0; i < 9; i++)
      u_host.wr(ADR[i], ~sh[i]);
    rd_all();
    $display("test refused writes done");
    do_reset();
    u_host.mode(MODE_DEV_CFG);
    u_host.wr(SENS_0_3_ADDR, 8'hE4);
    @(negedge mclk);
    chk("sens", button_sensitivity_code[7:0], 8'h90);
    u_host.wr(SUPP_LOW_ADDR, 8'h06);
    tick(10'h00E);
    chk("touched", button_touched, 10'h00A);
    u_host.wr(SUPP_LOW_ADDR, 8'h00);
    tick(10'h00E);
    chk("touched", button_touched, 10'h00E);
    $display("test sensitivity and suppression done");
    u_host.wr(DEB_ZERO_ADDR, 8'h03);
    tick(10'h000);
    tick(10'h001);
    tick(10'h001);
    tick(10'h000);
    tick(10'h001);
    tick(10'h001);
    chk("touched", button_touched, 10'h000);
    tick(10'h001);
    chk("touched", button_touched, 10'h001);
    u_host.wr(DEB_REST_ADDR, 8'h02);
    tick(10'h202);
    chk("touched", button_touched, 10'h000);
    tick(10'h202);
    chk("touched", button_touched, 10'h202);
    $display("test debounce done");
    do_reset();
    u_host.wr(TOGGLE_LOW_ADDR, 8'h01);
    tick(10'h003);
    // toggle state turns over one cycle after the touch and the pin a cycle later
    repeat (2) @(negedge mclk);
    chk("linked", button_linked_output_n, 10'h3FC);
    tick(10'h000);
    repeat (2) @(negedge mclk);
    chk("linked", button_linked_output_n, 10'h3FE);
    tick(10'h001);
    repeat (2) @(negedge mclk);
    chk("linked", button_linked_output_n, 10'h3FF);
    $display("test toggle done");
    // a save that never pulsed would leave its note behind
    chk("pending", img_q.size() + rd_q.size(), 72'h0);
    stop_test();
  end
endmodule : touch_button_config_regs_tb_top
`default_nettype wire
